// [pkg/bcsa_pkg.sv]
// Constants, state encodings and carriers for the bridge configuration space block.
// Assumes a single primary bus clock and that the bus pins are sampled synchronously.
package bcsa_pkg;

   // ---------------------------------------------------------------
   // Configuration offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_HEADER = 8'h0C;
   localparam logic [7:0] OFF_PF_WINDOW = 8'h24;
   localparam logic [7:0] OFF_PF_BASE_HI = 8'h28;
   localparam logic [7:0] OFF_PF_LIMIT_HI = 8'h2C;
   localparam logic [7:0] OFF_IO_HI = 8'h30;
   localparam logic [7:0] OFF_CAP_HEAD = 8'h34;
   localparam logic [7:0] OFF_BRIDGE_CTL = 8'h3C;
   localparam logic [7:0] OFF_DEV_SETUP = 8'h40;
   localparam logic [7:0] OFF_READ_PF = 8'h48;
   localparam logic [7:0] OFF_PORT_OPT = 8'h58;
   localparam logic [7:0] OFF_SERR_MASK = 8'h64;
   localparam logic [7:0] OFF_SERR_CLK = 8'h68;
   localparam logic [7:0] OFF_PM_CAP = 8'hDC;
   localparam logic [7:0] OFF_PM_CSR = 8'hE0;
   localparam logic [7:0] OFF_HOTSWAP = 8'hE4;
   localparam logic [7:0] OFF_RSVD_TOP = 8'hE8;

   // ---------------------------------------------------------------
   // Field positions and fixed values
   // ---------------------------------------------------------------
   localparam int HDR_TYPE_LSB = 16;
   localparam int CAP_ID_LSB = 0;
   localparam int CAP_NEXT_LSB = 8;
   localparam int CAP_WORD_LSB = 16;
   localparam int SERR_CAUSE_LSB = 16;
   localparam int HOTSWAP_CTL_LSB = 16;
   localparam logic [7:0] HDR_TYPE_BRIDGE = 8'h01;
   localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
   localparam logic [7:0] PM_CAP_ID = 8'h01;
   localparam logic [7:0] HOTSWAP_CAP_ID = 8'h06;
   localparam logic [7:0] HOTSWAP_NEXT = 8'h00;
   localparam logic [15:0] PM_CAP_WORD = 16'h0002;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [7:0] CAUSE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Writable bit masks
   // ---------------------------------------------------------------
   localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_BRIDGE_CTL = 32'hFFFF_00FF;
   localparam logic [31:0] MASK_LOW_BYTE = 32'h0000_00FF;
   localparam logic [31:0] MASK_LOW_HALF = 32'h0000_FFFF;
   localparam logic [31:0] MASK_PM_CSR = 32'h0000_0003;
   localparam logic [31:0] MASK_HOTSWAP_CTL = 32'h00FF_0000;

   // ---------------------------------------------------------------
   // Bus commands
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [1:0] TYPE0_CODE = 2'h0;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CLAIM = 4'b0010,
      ST_DATA = 4'b0100,
      ST_TURN = 4'b1000
   } bcsa_state_type;

   typedef struct packed {
      logic frame_n;
      logic irdy_n;
      logic idsel;
      logic [31:0] ad;
      logic [3:0] cbe_n;
   } bcsa_pci_in_type;

   typedef struct packed {
      logic [31:0] ad;
      logic ad_oe_n;
      logic devsel_n;
      logic trdy_n;
      logic stop_n;
      logic ctl_oe_n;
   } bcsa_pci_out_type;

   typedef struct packed {
      logic [31:0] pf_window;
      logic [31:0] pf_base_hi;
      logic [31:0] pf_limit_hi;
      logic [31:0] io_hi;
      logic [15:0] bridge_ctl;
      logic [7:0] irq_line;
      logic [31:0] dev_setup;
      logic [7:0] read_pf;
      logic [31:0] port_opt;
      logic [7:0] serr_mask;
      logic [15:0] sec_clk;
      logic [1:0] power_state;
      logic [7:0] hotswap_ctl;
   } bcsa_setup_type;

endpackage

// [rtl/bcsa_config_space.sv]
// Configuration space decoder and register bank of the bridge, primary side only.
// Assumes primary bus pins arrive synchronous to clk; pin wires are resolved outside.
`timescale 1ns/100ps
`default_nettype none

module bcsa_config_space (
   input wire logic clk,
   input wire logic rst_n,
   input wire bcsa_pkg::bcsa_pci_in_type pci_in,
   output bcsa_pkg::bcsa_pci_out_type pci_out,
   input wire logic [7:0] serr_event,
   output bcsa_pkg::bcsa_setup_type setup
);

   typedef struct packed {
      bcsa_pkg::bcsa_state_type st;
      logic is_write;
      logic [5:0] idx;
      logic [31:0] rd_data;
      logic [63:0][31:0] regs;
      logic [7:0] serr_cause;
   } bcsa_core_type;

   bcsa_core_type state_reg;
   bcsa_core_type state_next;

   // ---------------------------------------------------------------
   // Decode functions
   // ---------------------------------------------------------------
   function automatic logic [31:0] wr_mask(input logic [5:0] idx);
      logic [31:0] m;
      m = 32'h0000_0000;
      case (idx)
         bcsa_pkg::OFF_PF_WINDOW[7:2],
         bcsa_pkg::OFF_PF_BASE_HI[7:2],
         bcsa_pkg::OFF_PF_LIMIT_HI[7:2],
         bcsa_pkg::OFF_IO_HI[7:2],
         bcsa_pkg::OFF_DEV_SETUP[7:2],
         bcsa_pkg::OFF_PORT_OPT[7:2]: begin
            m = bcsa_pkg::MASK_FULL;
         end
         bcsa_pkg::OFF_BRIDGE_CTL[7:2]: begin
            m = bcsa_pkg::MASK_BRIDGE_CTL;
         end
         bcsa_pkg::OFF_READ_PF[7:2],
         bcsa_pkg::OFF_SERR_MASK[7:2]: begin
            m = bcsa_pkg::MASK_LOW_BYTE;
         end
         bcsa_pkg::OFF_SERR_CLK[7:2]: begin
            m = bcsa_pkg::MASK_LOW_HALF;
         end
         bcsa_pkg::OFF_PM_CSR[7:2]: begin
            m = bcsa_pkg::MASK_PM_CSR;
         end
         bcsa_pkg::OFF_HOTSWAP[7:2]: begin
            m = bcsa_pkg::MASK_HOTSWAP_CTL;
         end
         default: begin
            // Reserved dwords hold nothing, so writes there are dropped
            m = 32'h0000_0000;
         end
      endcase
      return m;
   endfunction

   function automatic logic [31:0] ro_value(input logic [5:0] idx);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (idx)
         bcsa_pkg::OFF_HEADER[7:2]: begin
            v[bcsa_pkg::HDR_TYPE_LSB +: 8] = bcsa_pkg::HDR_TYPE_BRIDGE;
         end
         bcsa_pkg::OFF_CAP_HEAD[7:2]: begin
            v[7:0] = bcsa_pkg::OFF_PM_CAP;
         end
         bcsa_pkg::OFF_BRIDGE_CTL[7:2]: begin
            v[15:8] = bcsa_pkg::IRQ_PIN_VAL;
         end
         bcsa_pkg::OFF_PM_CAP[7:2]: begin
            v[bcsa_pkg::CAP_ID_LSB +: 8] = bcsa_pkg::PM_CAP_ID;
            v[bcsa_pkg::CAP_NEXT_LSB +: 8] = bcsa_pkg::OFF_HOTSWAP;
            v[bcsa_pkg::CAP_WORD_LSB +: 16] = bcsa_pkg::PM_CAP_WORD;
         end
         bcsa_pkg::OFF_HOTSWAP[7:2]: begin
            v[bcsa_pkg::CAP_ID_LSB +: 8] = bcsa_pkg::HOTSWAP_CAP_ID;
            v[bcsa_pkg::CAP_NEXT_LSB +: 8] = bcsa_pkg::HOTSWAP_NEXT;
         end
         default: begin
            // Reserved space reads as zero
            v = 32'h0000_0000;
         end
      endcase
      return v;
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{~be_n[i]}};
      end
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Address phase decode
   // ---------------------------------------------------------------
   logic addr_hit;
   logic commit;
   logic [31:0] wmask;
   logic [31:0] cause_clear;

   // Only primary pins reach this decoder; nothing from the secondary side can
   always_comb begin
      addr_hit = ~pci_in.frame_n && pci_in.idsel
         && (pci_in.ad[1:0] == bcsa_pkg::TYPE0_CODE)
         && ((pci_in.cbe_n == bcsa_pkg::CMD_CFG_RD) || (pci_in.cbe_n == bcsa_pkg::CMD_CFG_WR));
   end

   always_comb begin
      commit = (state_reg.st == bcsa_pkg::ST_DATA) && ~pci_in.irdy_n;
      wmask = wr_mask(state_reg.idx) & lane_mask(pci_in.cbe_n);
      cause_clear = 32'h0000_0000;
      if (commit && state_reg.is_write && (state_reg.idx == bcsa_pkg::OFF_SERR_CLK[7:2])) begin
         cause_clear = pci_in.ad & lane_mask(pci_in.cbe_n);
      end
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // Set beats clear when an event lands on a write-one-to-clear
      state_next.serr_cause = (state_reg.serr_cause & ~cause_clear[bcsa_pkg::SERR_CAUSE_LSB +: 8])
         | serr_event;
      case (state_reg.st)
         bcsa_pkg::ST_IDLE: begin
            if (addr_hit) begin
               state_next.st = bcsa_pkg::ST_CLAIM;
               state_next.idx = pci_in.ad[7:2];
               state_next.is_write = pci_in.cbe_n[0];
            end
         end
         bcsa_pkg::ST_CLAIM: begin
            // Read data is taken here so the pins see a flopped value
            state_next.rd_data = (state_reg.regs[state_reg.idx] & wr_mask(state_reg.idx))
               | ro_value(state_reg.idx);
            if (state_reg.idx == bcsa_pkg::OFF_SERR_CLK[7:2]) begin
               state_next.rd_data[bcsa_pkg::SERR_CAUSE_LSB +: 8] = state_reg.serr_cause;
            end
            state_next.st = bcsa_pkg::ST_DATA;
         end
         bcsa_pkg::ST_DATA: begin
            if (commit) begin
               if (state_reg.is_write) begin
                  state_next.regs[state_reg.idx] = (state_reg.regs[state_reg.idx] & ~wmask)
                     | (pci_in.ad & wmask);
               end
               state_next.st = bcsa_pkg::ST_TURN;
            end
         end
         bcsa_pkg::ST_TURN: begin
            state_next.st = bcsa_pkg::ST_IDLE;
         end
         default: begin
            state_next.st = bcsa_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.st <= bcsa_pkg::ST_IDLE;
         state_reg.is_write <= 1'b0;
         state_reg.idx <= 6'h00;
         state_reg.rd_data <= bcsa_pkg::REG_RESET;
         state_reg.regs <= '0;
         state_reg.serr_cause <= bcsa_pkg::CAUSE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Single-dword target: stop with the first data phase so bursts disconnect
   always_comb begin
      pci_out.ad = state_reg.rd_data;
      pci_out.ad_oe_n = ~((state_reg.st == bcsa_pkg::ST_DATA) && ~state_reg.is_write);
      pci_out.devsel_n = ~((state_reg.st == bcsa_pkg::ST_CLAIM) || (state_reg.st == bcsa_pkg::ST_DATA));
      pci_out.trdy_n = ~(state_reg.st == bcsa_pkg::ST_DATA);
      pci_out.stop_n = ~(state_reg.st == bcsa_pkg::ST_DATA);
      // Turn cycle drives the strobes high before letting go
      pci_out.ctl_oe_n = (state_reg.st == bcsa_pkg::ST_IDLE);
   end

   // ---------------------------------------------------------------
   // Setup outputs to the forwarding logic
   // ---------------------------------------------------------------
   // Vendor registers only tune behaviour; defaults of zero give plain bridging
   always_comb begin
      setup.pf_window = state_reg.regs[bcsa_pkg::OFF_PF_WINDOW[7:2]];
      setup.pf_base_hi = state_reg.regs[bcsa_pkg::OFF_PF_BASE_HI[7:2]];
      setup.pf_limit_hi = state_reg.regs[bcsa_pkg::OFF_PF_LIMIT_HI[7:2]];
      setup.io_hi = state_reg.regs[bcsa_pkg::OFF_IO_HI[7:2]];
      setup.bridge_ctl = state_reg.regs[bcsa_pkg::OFF_BRIDGE_CTL[7:2]][31:16];
      setup.irq_line = state_reg.regs[bcsa_pkg::OFF_BRIDGE_CTL[7:2]][7:0];
      setup.dev_setup = state_reg.regs[bcsa_pkg::OFF_DEV_SETUP[7:2]];
      setup.read_pf = state_reg.regs[bcsa_pkg::OFF_READ_PF[7:2]][7:0];
      setup.port_opt = state_reg.regs[bcsa_pkg::OFF_PORT_OPT[7:2]];
      setup.serr_mask = state_reg.regs[bcsa_pkg::OFF_SERR_MASK[7:2]][7:0];
      setup.sec_clk = state_reg.regs[bcsa_pkg::OFF_SERR_CLK[7:2]][15:0];
      setup.power_state = state_reg.regs[bcsa_pkg::OFF_PM_CSR[7:2]][1:0];
      setup.hotswap_ctl = state_reg.regs[bcsa_pkg::OFF_HOTSWAP[7:2]][bcsa_pkg::HOTSWAP_CTL_LSB +: 8];
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic rd_phase;
   assign rd_phase = (state_reg.st == bcsa_pkg::ST_DATA) && ~state_reg.is_write;

   header_type_a: assert property (
      rd_phase && (state_reg.idx == bcsa_pkg::OFF_HEADER[7:2])
      |-> pci_out.ad[23:16] == 8'h01)
      else $error("header type byte is not 0x01");

   claim_sequence_a: assert property (
      (state_reg.st == bcsa_pkg::ST_IDLE) && addr_hit
      |=> !pci_out.devsel_n && pci_out.trdy_n ##1 !pci_out.devsel_n && !pci_out.trdy_n)
      else $error("type 0 cycle not claimed in order");

   index_capture_a: assert property (
      (state_reg.st == bcsa_pkg::ST_IDLE) && addr_hit
      |=> state_reg.idx == $past(pci_in.ad[7:2]))
      else $error("register index not taken from address bits 7:2");

   no_lane_write_a: assert property (
      commit && (pci_in.cbe_n == 4'hF) |=> $stable(state_reg.regs))
      else $error("write with no byte enabled changed state");

   vendor_write_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h10) && !pci_in.cbe_n[0]
      |=> state_reg.regs[16][7:0] == $past(pci_in.ad[7:0]))
      else $error("vendor setup byte not written");

   pm_cap_a: assert property (
      rd_phase && (state_reg.idx == 6'h37)
      |-> pci_out.ad == {16'h0002, 8'hE4, 8'h01})
      else $error("power capability dword wrong");

   hotswap_cap_a: assert property (
      rd_phase && (state_reg.idx == 6'h39)
      |-> pci_out.ad[15:0] == 16'h0006)
      else $error("hot-swap power_cap_identifier or link wrong");

   rsvd_access_a: assert property (
      commit && (state_reg.idx >= 6'h3A)
      |=> $stable(state_reg.regs) && (state_reg.st == bcsa_pkg::ST_TURN))
      else $error("reserved access changed state or did not finish");

   event_sticky_a: assert property (
      serr_event[0] |=> state_reg.serr_cause[0])
      else $error("event lost against clear");

   // ---------------------------------------------------------------
   // Handshake and field checks
   // ---------------------------------------------------------------
   // Target must keep its strobes until the initiator is ready, or data is lost
   wait_hold_a: assert property (
      (state_reg.st == bcsa_pkg::ST_DATA) && pci_in.irdy_n
      |=> !pci_out.devsel_n && !pci_out.trdy_n && !pci_out.stop_n)
      else $error("target strobes dropped before initiator ready");

   turn_release_a: assert property (
      commit
      |=> pci_out.devsel_n && pci_out.trdy_n && pci_out.stop_n && !pci_out.ctl_oe_n && pci_out.ad_oe_n
      ##1 pci_out.ctl_oe_n)
      else $error("turn cycle not driven high then released");

   refused_quiet_a: assert property (
      (state_reg.st == bcsa_pkg::ST_IDLE) && !addr_hit
      |=> pci_out.devsel_n && pci_out.ctl_oe_n)
      else $error("cycle claimed without a type 0 select");

   write_no_drive_a: assert property (
      (state_reg.st == bcsa_pkg::ST_DATA) && state_reg.is_write |-> pci_out.ad_oe_n)
      else $error("data lines driven during a write");

   read_path_a: assert property (
      rd_phase && (state_reg.idx == 6'h0A) |-> pci_out.ad == state_reg.regs[10])
      else $error("read data differs from the addressed dword");

   header_write_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h03) |=> $stable(state_reg.regs))
      else $error("write changed the header dword");

   lane_keep_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h0A) && pci_in.cbe_n[0]
      |=> state_reg.regs[10][7:0] == $past(state_reg.regs[10][7:0]))
      else $error("disabled byte lane was written");

   cause_clear_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h1A) && !pci_in.cbe_n[2] && pci_in.ad[16]
      && !serr_event[0] |=> !state_reg.serr_cause[0])
      else $error("cause flag not cleared by a written one");

   cap_head_a: assert property (
      rd_phase && (state_reg.idx == 6'h0D) |-> pci_out.ad == 32'h0000_00DC)
      else $error("capability list does not start at the power structure");

   pm_read_only_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h37) |=> $stable(state_reg.regs))
      else $error("write changed the power capability dword");

   hotswap_write_a: assert property (
      commit && state_reg.is_write && (state_reg.idx == 6'h39) && !pci_in.cbe_n[2]
      |=> state_reg.regs[57][23:16] == $past(pci_in.ad[23:16]))
      else $error("hot-swap control byte not written");

   read_cover_c: cover property (rd_phase && commit);
   write_cover_c: cover property (commit && state_reg.is_write);
   clear_cover_c: cover property (|cause_clear && |serr_event);
   wait_cover_c: cover property ((state_reg.st == bcsa_pkg::ST_DATA) && pci_in.irdy_n);
   rsvd_cover_c: cover property (commit && (state_reg.idx >= 6'h3A));

endmodule

`default_nettype wire

// [tb/bcsa_cfg_master.sv]
// Behavioural configuration master on the primary bus, with pin resolution.
// Assumes the device drives ad only while ad_oe_n is low.
`timescale 1ns/100ps
`default_nettype none
module bcsa_cfg_master (
   input wire logic clk,
   input wire bcsa_pkg::bcsa_pci_out_type pci_out,
   output var bcsa_pkg::bcsa_pci_in_type pci_in
);
   logic frame_n = 1'b1;
   logic irdy_n = 1'b1;
   logic idsel = 1'b0;
   logic drv = 1'b0;
   logic [31:0] m_ad = 32'h0000_0000;
   logic [3:0] m_cbe = 4'hF;
   logic [31:0] idle_pat = 32'h5A5A_C3C3;

   // ---------------------------------------------------------------
   // Pin resolution
   // ---------------------------------------------------------------
   // Released lines float: a toggling pattern, never the held value
   always @(posedge clk) idle_pat <= ~idle_pat;
   assign pci_in = {frame_n, irdy_n, idsel, drv ? m_ad : (!pci_out.ad_oe_n ? pci_out.ad : idle_pat),
      (!frame_n || !irdy_n) ? m_cbe : idle_pat[3:0]};

   // ---------------------------------------------------------------
   // One single-dword access; waits holds irdy off to act slow
   // ---------------------------------------------------------------
   task automatic access(input logic [3:0] cmd, input logic sel, input logic [7:0] addr,
         input logic [3:0] be_n, input logic [31:0] wdata, input int waits,
         output logic [31:0] rdata, output logic claimed, output logic done);
      claimed = 1'b0;
      done = 1'b0;
      rdata = 32'h0000_0000;
      repeat (2) @(negedge clk);
      frame_n = 1'b0;
      idsel = sel;
      drv = 1'b1;
      m_ad = {24'h00_0000, addr};
      m_cbe = cmd;
      @(negedge clk);
      idsel = 1'b0;
      m_cbe = be_n;
      m_ad = wdata;
      drv = (cmd != bcsa_pkg::CMD_CFG_RD);
      repeat (waits) @(negedge clk);
      frame_n = 1'b1;
      irdy_n = 1'b0;
      // Strobes are looked at mid-cycle, where settled; the next rising edge completes
      for (int n = 0; n < 8 && !done; n++) begin
         if (pci_out.devsel_n === 1'b0 && pci_out.ctl_oe_n === 1'b0) claimed = 1'b1;
         if (pci_out.trdy_n === 1'b0 && pci_out.stop_n === 1'b0 && pci_out.ctl_oe_n === 1'b0) begin
            done = 1'b1;
            rdata = pci_in.ad;
         end
         @(negedge clk);
      end
      irdy_n = 1'b1;
      drv = 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/bridge_config_space_access_test.sv]
// Self-checking bench for the configuration space block.
// Assumes the master model in bcsa_cfg_master.sv resolves the shared pins.
`timescale 1ns/100ps
`default_nettype none
module bridge_config_space_access_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] serr_event = 8'h00;
   bcsa_pkg::bcsa_pci_in_type pci_in;
   bcsa_pkg::bcsa_pci_out_type pci_out;
   bcsa_pkg::bcsa_setup_type setup;
   bcsa_pkg::bcsa_setup_type snap;
   int n_mismatch = 0;
   int num_checks = 0;
   logic [31:0] rd;
   logic [31:0] e;
   logic [31:0] p;
   logic c;
   logic d;
   logic [7:0] t_off [15] = '{8'h0C, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C, 8'h40, 8'h48, 8'h58,
      8'h64, 8'h68, 8'hDC, 8'hE0, 8'hE4};
   logic [31:0] t_msk [15] = '{32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0,
      32'hFFFF_00FF, 32'hFFFF_FFFF, 32'hFF, 32'hFFFF_FFFF, 32'hFF, 32'hFFFF, 32'h0, 32'h3, 32'hFF_0000};
   logic [31:0] t_fix [15] = '{32'h0001_0000, 32'h0, 32'h0, 32'h0, 32'h0, 32'hDC, 32'h100, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0002_E401, 32'h0, 32'h6};
   logic [7:0] t_rsv [8] = '{8'h00, 8'h10, 8'h38, 8'h44, 8'h5C, 8'hB4, 8'hE8, 8'hFC};

   always #25 clk = ~clk;

   bcsa_config_space bcsa_config_space_inst (.clk(clk), .rst_n(rst_n), .pci_in(pci_in), .pci_out(pci_out),
      .serr_event(serr_event), .setup(setup));
   bcsa_cfg_master bcsa_cfg_master_inst (.clk(clk), .pci_out(pci_out), .pci_in(pci_in));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk_setup(input bcsa_pkg::bcsa_setup_type exp);
      num_checks++;
      if (setup !== exp) begin
         n_mismatch++;
         $display("unexpected setup: expected %h, seen %h", exp, setup);
      end
   endtask

   // Every claimed access must finish; a hang ends the run
   task automatic xfer(input logic [3:0] cmd, input logic [7:0] addr, input logic [3:0] be_n,
         input logic [31:0] data, input int waits);
      logic cl;
      logic dn;
      bcsa_cfg_master_inst.access(cmd, 1'b1, addr, be_n, data, waits, rd, cl, dn);
      check($sformatf("completion at %h", addr), 32'h1, {31'h0, dn});
      if (dn !== 1'b1) tally_and_finish();
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input int waits);
      xfer(bcsa_pkg::CMD_CFG_RD, addr, 4'h0, 32'h0, waits);
      check($sformatf("read %h", addr), exp, rd);
   endtask

   task automatic chk_defaults();
      for (int i = 0; i < 15; i++) rd_chk(t_off[i], t_fix[i], 0);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("unexpected run length: expected under 60000 cycles, seen more");
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk_setup('0);
      chk_defaults();
      $display("test reset values done");

      for (int k = 0; k < 2; k++) begin
         p = k ? 32'h5A3C_A5C3 : 32'hA5C3_5A3C;
         for (int i = 0; i < 15; i++) xfer(bcsa_pkg::CMD_CFG_WR, t_off[i], 4'h0, p, i % 3);
         for (int i = 0; i < 15; i++) rd_chk(t_off[i], (p & t_msk[i]) | t_fix[i], i % 2);
         check("pf base high", p, setup.pf_base_hi);
         check("bridge ctl", {16'h0, p[31:16]}, {16'h0, setup.bridge_ctl});
         check("power state", {30'h0, p[1:0]}, {30'h0, setup.power_state});
         check("hotswap ctl", {24'h0, p[23:16]}, {24'h0, setup.hotswap_ctl});
      end
      $display("test register map done");

      for (int b = 0; b < 16; b++) begin
         xfer(bcsa_pkg::CMD_CFG_WR, 8'h28, 4'h0, 32'hFFFF_FFFF, 0);
         xfer(bcsa_pkg::CMD_CFG_WR, 8'h28, b[3:0], 32'h0000_0000, b % 2);
         for (int j = 0; j < 4; j++) e[8*j+:8] = {8{b[j]}};
         rd_chk(8'h28, e, 0);
      end
      $display("test byte enables done");

      snap = setup;
      for (int i = 0; i < 8; i++) xfer(bcsa_pkg::CMD_CFG_WR, t_rsv[i], 4'h0, 32'hFFFF_FFFF, 0);
      for (int i = 0; i < 8; i++) xfer(bcsa_pkg::CMD_CFG_RD, t_rsv[i], 4'h0, 32'h0, 1);
      chk_setup(snap);
      rd_chk(8'h0C, 32'h0001_0000, 0);
      $display("test reserved offsets done");

      // Memory command, deselected config, type 1 address: none claimed
      bcsa_cfg_master_inst.access(4'h6, 1'b1, 8'h24, 4'h0, 32'hFFFF_FFFF, 0, rd, c, d);
      check("memory claim", 32'h0, {31'h0, c});
      bcsa_cfg_master_inst.access(bcsa_pkg::CMD_CFG_WR, 1'b0, 8'h24, 4'h0, 32'hFFFF_FFFF, 0, rd, c, d);
      check("deselected claim", 32'h0, {31'h0, c});
      bcsa_cfg_master_inst.access(bcsa_pkg::CMD_CFG_WR, 1'b1, 8'h25, 4'h0, 32'hFFFF_FFFF, 0, rd, c, d);
      check("type 1 claim", 32'h0, {31'h0, c});
      rd_chk(8'h24, 32'h5A3C_A5C3, 0);
      $display("test refused cycles done");

      xfer(bcsa_pkg::CMD_CFG_WR, 8'h68, 4'h0, 32'h00FF_0000, 0);
      @(negedge clk);
      serr_event = 8'h81;
      @(negedge clk);
      serr_event = 8'h00;
      rd_chk(8'h68, 32'h0081_0000, 0);
      xfer(bcsa_pkg::CMD_CFG_WR, 8'h68, 4'hB, 32'h0001_0000, 0);
      rd_chk(8'h68, 32'h0080_0000, 2);
      // Event lands on the very edge that writes the clear: the set must win
      fork
         xfer(bcsa_pkg::CMD_CFG_WR, 8'h68, 4'hB, 32'h0081_0000, 0);
         begin
            repeat (4) @(negedge clk);
            serr_event = 8'h01;
            @(negedge clk);
            serr_event = 8'h00;
         end
      join
      rd_chk(8'h68, 32'h0001_0000, 0);
      $display("test cause flags done");

      @(negedge clk);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      chk_setup('0);
      rst_n = 1'b1;
      chk_defaults();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
